// ### testbench/isptm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core side: notes each newly raised request and what it carried.
module isptm_core_model (
  input wire logic i_clk, i_nrst, i_irq,
  input wire logic [2:0] i_prio,
  input wire logic [5:0] i_vec,
  output logic o_took,
  output logic [8:0] o_seen
);
  logic irq_q; // Request level one cycle ago.
  // Fields are trusted only in single-vector use, as this core runs.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) irq_q <= 1'b0;
    else irq_q <= i_irq;
  end
  assign o_took = i_irq && !irq_q;
  assign o_seen = {i_prio, i_vec};
endmodule
`default_nettype wire

// ### testbench/isptm_properties.sv
`timescale 1ns/1ps
`default_nettype none
module isptm_properties
  import isptm_pkg::*;
(
  input wire logic i_sys_clk, i_nrst, i_psel, i_penable, i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata, o_prdata,
  input wire logic o_pready, o_pslverr, i_irq_valid, o_core_irq, o_irq,
  input wire logic [2:0] i_irq_prio, o_core_prio,
  input wire logic [5:0] i_irq_vec, o_core_vec
);
  // ------------------------------------------------------------
  // Bus and release checks, one clock domain.
  // ------------------------------------------------------------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  wire acc = i_psel && i_penable; // Access phase of the master.
  rdy_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready wider than one cycle");
  rdy_after_a: assert property (acc && !o_pready |=> o_pready)
    else $error("ready late");
  rdy_cause_a: assert property (o_pready |-> $past(acc))
    else $error("ready without access");
  err_only_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  err_unmap_a: assert property (o_pready && i_paddr > ISPTM_OFS_COUNT |-> o_pslverr)
    else $error("unmapped not refused");
  ok_map_a: assert property (o_pready && i_paddr[1:0] == 2'h0
    && i_paddr <= ISPTM_OFS_COUNT |-> !o_pslverr) else $error("mapped refused");
  err_zero_a: assert property (o_pready && o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
    else $error("refused read not zero");
  stat_zero_a: assert property (o_pready && !i_pwrite && i_paddr == ISPTM_OFS_STATUS
    |-> o_prdata[31:11] == 21'h0 && o_prdata[7:6] == 2'h0) else $error("status spare bits set");
  core_clear_a: assert property ($fell(o_core_irq) |-> !$past(i_irq_valid))
    else $error("core request dropped early");
  cover property (o_pready && o_pslverr);
  cover property ($rose(o_core_irq));
  cover property ($rose(o_irq));
endmodule
bind isptm_top isptm_properties u_props (.*);
`default_nettype wire

// ### testbench/isptm_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module isptm_tb_top;
  import isptm_pkg::*;
  logic i_sys_clk = 0, i_nrst = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [7:0] i_paddr = 8'h0;
  logic [31:0] i_pwdata = 32'h0, rv;
  logic i_irq_valid = 0;
  logic [2:0] i_irq_prio = 3'h0;
  logic [5:0] i_irq_vec = 6'h0;
  wire logic [31:0] o_prdata;
  wire logic o_pready, o_pslverr, o_core_irq, o_irq, took;
  wire logic [2:0] o_core_prio;
  wire logic [5:0] o_core_vec;
  wire logic [8:0] seen;
  int mismatches = 0, checks = 0, seed = 50, n;
  logic [33:0] apbq[$]; // Notes: read flag, error, data.
  logic [8:0] coreq[$]; // Notes: priority and vector.
  logic [33:0] q;
  always #2 i_sys_clk = ~i_sys_clk;
  isptm_top u_dut (.*);
  isptm_core_model u_core (.i_clk(i_sys_clk), .i_nrst(i_nrst), .i_irq(o_core_irq),
    .i_prio(o_core_prio), .i_vec(o_core_vec), .o_took(took), .o_seen(seen));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Master holds the request until ready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic er);
    int k;
    apbq.push_back({~w, er, e});
    i_psel <= 1'b1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
    @(posedge i_sys_clk) i_penable <= 1'b1;
    k = 0;
    do begin @(posedge i_sys_clk); k++; end while (o_pready !== 1'b1 && k < 20);
    if (o_pready !== 1'b1) begin mismatches++; results(); end
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    // One idle edge keeps the next setup from driving psel again in this time step.
    @(posedge i_sys_clk);
  endtask
  // Watchers take the oldest note whenever a result shows.
  always @(posedge i_sys_clk) if (o_pready === 1'b1) begin
    q = apbq.size() ? apbq.pop_front() : 34'h3_FFFF_FFFF;
    chk("pslverr", 32'(q[32]), 32'(o_pslverr));
    if (q[33]) chk("prdata", q[31:0], o_prdata);
  end
  always @(posedge i_sys_clk) if (took === 1'b1)
    chk("core", coreq.size() ? 32'(coreq.pop_front()) : 32'hX, 32'(seen));
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    @(posedge i_sys_clk);
    for (int a = 0; a <= 'h14; a += 4) apb(0, a[7:0], 0, 0, a == 'h14);
    apb(1, 8'h14, 32'h0000_00A5, 0, 1);
    rv = $random(seed);
    apb(1, ISPTM_OFS_RELOAD, rv, 0, 0);
    apb(0, ISPTM_OFS_RELOAD, 0, rv, 0);
    apb(1, ISPTM_OFS_STATUS, ~rv, 0, 0);
    apb(0, ISPTM_OFS_STATUS, 0, ~rv & 32'h0000_073F, 0);
    apb(1, ISPTM_OFS_RELOAD, 32'h3, 0, 0);
    apb(1, ISPTM_OFS_MASK, 0, 0, 0);
    rv = $random(seed);
    coreq.push_back(rv[8:0]);
    i_irq_prio <= rv[8:6]; i_irq_vec <= rv[5:0]; i_irq_valid <= 1'b1;
    n = 0;
    do begin @(posedge i_sys_clk); n++; end while (o_core_irq !== 1'b1 && n < 50);
    chk("release delay", 32'd6, n);
    if (o_core_irq !== 1'b1) results();
    apb(0, ISPTM_OFS_EVENTS, 0, 32'h3, 0);
    chk("masked irq", 0, 32'(o_irq));
    apb(1, ISPTM_OFS_MASK, 32'h3, 0, 0);
    @(posedge i_sys_clk);
    chk("irq", 1, 32'(o_irq));
    apb(0, ISPTM_OFS_STATUS, 0, {21'h0, rv[8:6], 2'h0, rv[5:0]}, 0);
    i_irq_valid <= 1'b0;
    n = 0;
    do begin @(posedge i_sys_clk); n++; end while (o_core_irq !== 1'b0 && n < 20);
    chk("core clear", 0, 32'(o_core_irq));
    if (o_core_irq !== 1'b0) results();
    apb(1, ISPTM_OFS_EVENTS, 32'h3, 0, 0);
    apb(0, ISPTM_OFS_EVENTS, 0, 0, 0);
    chk("irq clear", 0, 32'(o_irq));
    chk("core left", 0, coreq.size());
    results();
  end
endmodule
`default_nettype wire

// ### verilog/isptm_pkg.sv
package isptm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the APB bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ISPTM_OFS_STATUS = 8'h00; // Interrupt status register.
  localparam logic [7:0] ISPTM_OFS_RELOAD = 8'h04; // Proximity timer reload register.
  localparam logic [7:0] ISPTM_OFS_EVENTS = 8'h08; // Sticky event flags, write one to clear.
  localparam logic [7:0] ISPTM_OFS_MASK = 8'h0C; // Event mask, one enables the event.
  localparam logic [7:0] ISPTM_OFS_COUNT = 8'h10; // Live proximity timer count, read only.

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int ISPTM_PRIO_LSB = 8; // Priority field occupies bits 10:8.
  localparam int ISPTM_PRIO_W = 3; // Width of the priority field.
  localparam int ISPTM_VEC_LSB = 0; // Vector field occupies bits 5:0.
  localparam int ISPTM_VEC_W = 6; // Width of the vector field.
  localparam int ISPTM_EVT_W = 2; // Number of event flags.
  localparam int ISPTM_EVT_TRIG = 0; // Timer was triggered by an interrupt event.
  localparam int ISPTM_EVT_REL = 1; // Timer expired and released the request.

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] ISPTM_RST_STATUS = 32'h0000_0000; // Status after reset.
  localparam logic [31:0] ISPTM_RST_RELOAD = 32'h0000_0000; // Reload after reset.
  localparam logic [31:0] ISPTM_RST_COUNT = 32'h0000_0000; // Count after reset.
  localparam logic [1:0] ISPTM_RST_EVT = 2'h0; // Flags and mask after reset.

  // ----------------------------------------------------------------
  // Timer state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ISPTM_IDLE = 2'b01, // No request held.
    ISPTM_HOLD = 2'b10  // Request held while the timer counts down.
  } isptm_state_e;

endpackage

// ### verilog/isptm_top.sv
// Overview of operation
// - Status shows latest delivered interrupt priority.
// - Status shows currently presented vector number.
// - Reload value loads timer on interrupt trigger.
// - Unimplemented status bits read as zero.
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module isptm_top (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // APB slave port.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Interrupt request from the source arbitration.
  input wire logic i_irq_valid,
  input wire logic [isptm_pkg::ISPTM_PRIO_W-1:0] i_irq_prio,
  input wire logic [isptm_pkg::ISPTM_VEC_W-1:0] i_irq_vec,
  // Request presented to the processor core.
  output logic o_core_irq,
  output logic [isptm_pkg::ISPTM_PRIO_W-1:0] o_core_prio,
  output logic [isptm_pkg::ISPTM_VEC_W-1:0] o_core_vec,
  // Summary interrupt line.
  output logic o_irq
);
  import isptm_pkg::*;

  // ----------------------------------------------------------------
  // State declarations
  // ----------------------------------------------------------------
  isptm_state_e state_q, state_d; // Timer state.
  logic [31:0] reload_q, reload_d; // Software reload value.
  logic [31:0] count_q, count_d; // Live down counter.
  logic [ISPTM_PRIO_W-1:0] prio_q, prio_d; // Latest delivered priority.
  logic [ISPTM_VEC_W-1:0] vec_q, vec_d; // Presented vector.
  logic [ISPTM_PRIO_W-1:0] hprio_q, hprio_d; // Priority of the held request.
  logic [ISPTM_VEC_W-1:0] hvec_q, hvec_d; // Vector of the held request.
  logic core_irq_q, core_irq_d; // Request line to the core.
  logic [ISPTM_EVT_W-1:0] evt_q, evt_d; // Sticky event flags.
  logic [ISPTM_EVT_W-1:0] mask_q, mask_d; // Event mask.
  logic irq_q, irq_d; // Summary interrupt.
  logic [31:0] prdata_q, prdata_d; // Read data register.
  logic pready_q, pready_d; // Ready register.
  logic pslverr_q, pslverr_d; // Error register.
  logic [ISPTM_EVT_W-1:0] evt_set; // Events raised this cycle.

  // Access phase of a transfer; the slave answers one cycle later.
  // Writes land at the first access edge, while the master still holds the request.
  logic acc;
  logic wr;
  assign acc = i_psel & i_penable & ~pready_q;
  assign wr = acc & i_pwrite;

  // Decodes a byte address into a known-register flag.
  function automatic logic isptm_mapped(input logic [7:0] a);
    isptm_mapped = (a == ISPTM_OFS_STATUS) || (a == ISPTM_OFS_RELOAD) ||
                   (a == ISPTM_OFS_EVENTS) || (a == ISPTM_OFS_MASK) ||
                   (a == ISPTM_OFS_COUNT);
  endfunction

  // ----------------------------------------------------------------
  // Proximity timer and request holding
  // ----------------------------------------------------------------
  // An incoming request arms the timer from the reload value; the request is held back
  // from the core until the count reaches zero, which coalesces bursts of interrupts.
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    hprio_d = hprio_q;
    hvec_d = hvec_q;
    prio_d = prio_q;
    vec_d = vec_q;
    core_irq_d = core_irq_q;
    evt_set = '0;
    case (state_q)
      ISPTM_IDLE: begin
        if (i_irq_valid) begin
          count_d = reload_q;
          hprio_d = i_irq_prio;
          hvec_d = i_irq_vec;
          evt_set[ISPTM_EVT_TRIG] = 1'b1;
          state_d = ISPTM_HOLD;
        end
      end
      ISPTM_HOLD: begin
        // A newer request updates what is held but does not restart the count.
        if (i_irq_valid) begin
          hprio_d = i_irq_prio;
          hvec_d = i_irq_vec;
        end
        if (count_q == 32'h0000_0000) begin
          core_irq_d = 1'b1;
          prio_d = i_irq_valid ? i_irq_prio : hprio_q;
          vec_d = i_irq_valid ? i_irq_vec : hvec_q;
          evt_set[ISPTM_EVT_REL] = 1'b1;
          state_d = ISPTM_IDLE;
        end else begin
          count_d = count_q - 32'h0000_0001;
        end
      end
      default: begin
        state_d = ISPTM_IDLE;
      end
    endcase
    // The core request drops once the source withdraws it and the timer is idle.
    if (core_irq_q && !i_irq_valid && state_q == ISPTM_IDLE) begin
      core_irq_d = 1'b0;
    end
    // Software may also write the status fields directly.
    if (wr && i_paddr == ISPTM_OFS_STATUS) begin
      prio_d = i_pwdata[ISPTM_PRIO_LSB +: ISPTM_PRIO_W];
      vec_d = i_pwdata[ISPTM_VEC_LSB +: ISPTM_VEC_W];
    end
  end

  // Timer state registers; the reset branch loads constants only, so the flops clear
  // at once without waiting for a clock edge.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ISPTM_IDLE;
      count_q <= ISPTM_RST_COUNT;
      hprio_q <= '0;
      hvec_q <= '0;
      prio_q <= ISPTM_RST_STATUS[ISPTM_PRIO_LSB +: ISPTM_PRIO_W];
      vec_q <= ISPTM_RST_STATUS[ISPTM_VEC_LSB +: ISPTM_VEC_W];
      core_irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      hprio_q <= hprio_d;
      hvec_q <= hvec_d;
      prio_q <= prio_d;
      vec_q <= vec_d;
      core_irq_q <= core_irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Register file, events and APB answer
  // ----------------------------------------------------------------
  // Reads return in the cycle after the access phase starts; an unmapped address
  // answers with pslverr and zero data so firmware faults are visible.
  always_comb begin
    reload_d = reload_q;
    mask_d = mask_q;
    evt_d = evt_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (wr && i_paddr == ISPTM_OFS_RELOAD) begin
      reload_d = i_pwdata;
    end
    if (wr && i_paddr == ISPTM_OFS_MASK) begin
      mask_d = i_pwdata[ISPTM_EVT_W-1:0];
    end
    if (wr && i_paddr == ISPTM_OFS_EVENTS) begin
      evt_d = evt_q & ~i_pwdata[ISPTM_EVT_W-1:0];
    end
    // A new event wins over a clear in the same cycle.
    evt_d = evt_d | evt_set;
    irq_d = |(evt_d & mask_d);
    if (acc) begin
      pready_d = 1'b1;
      pslverr_d = ~isptm_mapped(i_paddr);
      prdata_d = 32'h0000_0000;
      if (!i_pwrite) begin
        case (i_paddr)
          ISPTM_OFS_STATUS: begin
            prdata_d[ISPTM_PRIO_LSB +: ISPTM_PRIO_W] = prio_q;
            prdata_d[ISPTM_VEC_LSB +: ISPTM_VEC_W] = vec_q;
          end
          ISPTM_OFS_RELOAD: prdata_d = reload_q;
          ISPTM_OFS_EVENTS: prdata_d[ISPTM_EVT_W-1:0] = evt_q;
          ISPTM_OFS_MASK: prdata_d[ISPTM_EVT_W-1:0] = mask_q;
          ISPTM_OFS_COUNT: prdata_d = count_q;
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // Register file and bus answer flops; the APB outputs and o_irq are taken straight
  // from these, which keeps decode paths out of the output timing.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      reload_q <= ISPTM_RST_RELOAD;
      mask_q <= ISPTM_RST_EVT;
      evt_q <= ISPTM_RST_EVT;
      irq_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      reload_q <= reload_d;
      mask_q <= mask_d;
      evt_q <= evt_d;
      irq_q <= irq_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Outputs come straight from flip-flops.
  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_core_irq = core_irq_q;
  assign o_core_prio = prio_q;
  assign o_core_vec = vec_q;
  assign o_irq = irq_q;

endmodule

`default_nettype wire
